// file: rtl/sebp_map.svh
`ifndef SEBP_MAP_SVH
`define SEBP_MAP_SVH

`define SEBP_WORD_W           16
`define SEBP_PAGE_WORDS       4
`define SEBP_WORDS_DEFAULT    256
`define SEBP_ADDR_BITS_SMALL  6
`define SEBP_ADDR_BITS_LARGE  8
`define SEBP_OPC_BITS         2

`define SEBP_OP_READ          2'h2
`define SEBP_OP_WRITE         2'h1
`define SEBP_OP_PAGE          2'h3
`define SEBP_OP_EXT           2'h0
`define SEBP_SUB_UNLOCK       2'h3
`define SEBP_SUB_LOCK         2'h0
`define SEBP_SUB_FILL         2'h1

`define SEBP_SYS_CLK_MHZ      250
`define SEBP_PROG_TIME_OLD_US 10000
`define SEBP_PROG_TIME_NEW_US 5000
`define SEBP_PROG_CYC_OLD     (`SEBP_PROG_TIME_OLD_US * `SEBP_SYS_CLK_MHZ)
`define SEBP_PROG_CYC_NEW     (`SEBP_PROG_TIME_NEW_US * `SEBP_SYS_CLK_MHZ)
`define SEBP_TIMER_W          22

`define SEBP_PROT_ADDR_RST    8'hFF
`define SEBP_PROT_CLR_RST     1'h1
`define SEBP_FCNT_MAX         3'h5

`endif

// file: rtl/sebp_pkg.sv
`include "sebp_map.svh"

package sebp_pkg;

  typedef enum logic [2:0] {
    SEBP_P_IDLE = 3'h1,
    SEBP_P_FILL = 3'h2,
    SEBP_P_WAIT = 3'h4
  } sebp_prog_state_type;

  typedef enum logic [5:0] {
    SEBP_L_IDLE = 6'h01,
    SEBP_L_OPC  = 6'h02,
    SEBP_L_ADDR = 6'h04,
    SEBP_L_DATA = 6'h08,
    SEBP_L_READ = 6'h10,
    SEBP_L_SKIP = 6'h20
  } sebp_link_state_type;

  typedef struct packed {
    logic                      busy_s1;
    logic                      busy_s2;
    logic                      seen_busy;
    sebp_link_state_type       state;
    logic [4:0]                cnt;
    logic [1:0]                opc;
    logic                      pre;
    logic [7:0]                addr;
    logic [15:0]               shreg;
    logic [15:0]               word_hold;
    logic                      tgl;
    logic [7:0]                ptr;
    logic                      q;
    logic                      q_oe;
  } sebp_link_type;

  typedef struct packed {
    logic                      cs_s1;
    logic                      cs_s2;
    logic                      cs_d;
    logic                      tg_s1;
    logic                      tg_s2;
    logic                      tg_d;
    sebp_prog_state_type       state;
    logic [`SEBP_TIMER_W-1:0]  timer;
    logic [7:0]                fill_ptr;
    logic [2:0]                fcnt;
    logic [1:0]                op;
    logic                      pre;
    logic [7:0]                addr;
    logic [3:0][15:0]          words;
    logic                      wr_go;
    logic [2:0]                wr_n;
    logic                      busy;
    logic                      wen;
    logic [7:0]                prot_addr;
    logic                      prot_clr;
    logic                      otp;
  } sebp_core_type;

endpackage

// file: rtl/sebp_link.sv
`timescale 1ns/1ps
`default_nettype none
module sebp_link
  import sebp_pkg::*;
#(
  parameter int WORDS = `SEBP_WORDS_DEFAULT,
  parameter int ABITS = `SEBP_ADDR_BITS_LARGE
) (
  input  wire logic        sclk,
  input  wire logic        cs,
  input  wire logic        din,
  input  wire logic        pre_pin,
  input  wire logic        busy,
  input  wire logic [15:0] rd_word,
  output logic      [7:0]  rd_ptr,
  output logic      [1:0]  hdr_op,
  output logic             hdr_pre,
  output logic      [7:0]  hdr_addr,
  output logic      [15:0] word_hold,
  output logic             word_tgl,
  output logic             q,
  output logic             q_oe
);
  localparam logic [7:0] PTR_MASK = 8'(WORDS - 1);
  localparam int         SUB_HI   = ABITS - 1;
  localparam logic [4:0] ADDR_END = 5'(ABITS - 1);

  sebp_link_type l_reg;
  sebp_link_type l_next;
  logic [7:0]    addr_full;
  logic [1:0]    sub;
  logic          needs_data;

  always_comb begin
    l_next       = l_reg;
    addr_full    = {l_reg.addr[6:0], din};
    sub          = addr_full[SUB_HI -: 2];
    needs_data   = !l_reg.pre && (l_reg.opc == `SEBP_OP_WRITE ||
                   l_reg.opc == `SEBP_OP_PAGE ||
                   (l_reg.opc == `SEBP_OP_EXT && sub == `SEBP_SUB_FILL));
    l_next.busy_s1 = busy;
    l_next.busy_s2 = l_reg.busy_s1;
    case (l_reg.state)
      SEBP_L_IDLE: begin
        if (l_reg.busy_s2) begin
          l_next.seen_busy = 1'b1;
          l_next.q         = 1'b0;
          l_next.q_oe      = 1'b1;
        end else if (din) begin
          l_next.state = SEBP_L_OPC;
          l_next.pre   = pre_pin;
          l_next.cnt   = 5'h00;
          l_next.q_oe  = 1'b0;
        end else if (l_reg.seen_busy) begin
          l_next.q    = 1'b1;
          l_next.q_oe = 1'b1;
        end
      end
      SEBP_L_OPC: begin
        l_next.opc = {l_reg.opc[0], din};
        l_next.cnt = l_reg.cnt + 5'h01;
        if (l_reg.cnt == 5'(`SEBP_OPC_BITS - 1)) begin
          l_next.state = SEBP_L_ADDR;
          l_next.cnt   = 5'h00;
        end
      end
      SEBP_L_ADDR: begin
        l_next.addr = addr_full;
        l_next.cnt  = l_reg.cnt + 5'h01;
        if (l_reg.cnt == ADDR_END) begin
          l_next.tgl = ~l_reg.tgl;
          l_next.cnt = 5'h00;
          if (!l_reg.pre && l_reg.opc == `SEBP_OP_READ) begin
            l_next.state = SEBP_L_READ;
            l_next.ptr   = addr_full & PTR_MASK;
            l_next.q     = 1'b0;
            l_next.q_oe  = 1'b1;
            l_next.cnt   = 5'h0F;
          end else if (needs_data) begin
            l_next.state = SEBP_L_DATA;
          end else begin
            l_next.state = SEBP_L_SKIP;
          end
        end
      end
      SEBP_L_DATA: begin
        l_next.shreg = {l_reg.shreg[14:0], din};
        l_next.cnt   = l_reg.cnt + 5'h01;
        if (l_reg.cnt == 5'h0F) begin
          l_next.word_hold = {l_reg.shreg[14:0], din};
          l_next.tgl       = ~l_reg.tgl;
          l_next.cnt       = 5'h00;
        end
      end
      SEBP_L_READ: begin
        l_next.q   = rd_word[l_reg.cnt[3:0]];
        l_next.cnt = l_reg.cnt - 5'h01;
        if (l_reg.cnt == 5'h00) begin
          l_next.ptr = (l_reg.ptr + 8'h01) & PTR_MASK;
          l_next.cnt = 5'h0F;
        end
      end
      SEBP_L_SKIP: begin
        l_next.q_oe = 1'b0;
      end
      default: begin
        l_next.state = SEBP_L_IDLE;
      end
    endcase
  end

  // The frame itself ends everything here: the serial clock may stop.
  always_ff @(posedge sclk or negedge cs) begin
    if (!cs) begin
      l_reg       <= '0;
      l_reg.state <= SEBP_L_IDLE;
    end else begin
      l_reg <= l_next;
    end
  end

  assign rd_ptr    = l_reg.ptr;
  assign hdr_op    = l_reg.opc;
  assign hdr_pre   = l_reg.pre;
  assign hdr_addr  = l_reg.addr;
  assign word_hold = l_reg.word_hold;
  assign word_tgl  = l_reg.tgl;
  assign q         = l_reg.q;
  assign q_oe      = l_reg.q_oe;

endmodule
`default_nettype wire

// file: rtl/sebp_top.sv
// Functional notes
// - Storage of 16-bit words: 256, 128 or 64.
// - Read loads pointer, shifts out addressed word.
// - Pointer increments; stream continues while selected.
// - Pointer wraps from top address to zero.
// - Page program stores up to four words.
// - Single write programs one unprotected word.
// - Page refused entirely if any word protected.
// - Fill-all programs every word with pattern only when protection clear.
// - Protection register defines write-refusing area.
// - Lock bit freezes protection register until reset.
// - Programming self-timed, independent of serial clock.
// - Writes overwrite without separate erase.
// - Busy shown on output while selected; ready only after busy seen.
// - Program cycle at most 10 or 5 ms.
// - Start bit, two opcode bits, then address.
// - Opcode and leading address bits select operation.
// - Power-up resets and leaves writes locked.
`timescale 1ns/1ps
`default_nettype none
module sebp_top
  import sebp_pkg::*;
#(
  parameter int WORDS       = `SEBP_WORDS_DEFAULT,
  parameter int PROG_CYCLES = `SEBP_PROG_CYC_OLD
) (
  input  wire logic sys_clk,
  input  wire logic reset_n,
  input  wire logic sclk,
  input  wire logic cs,
  input  wire logic din,
  input  wire logic pre_pin,
  output logic      q,
  output logic      q_oe,
  output logic      prog_busy,
  output logic      write_unlocked,
  output logic      prot_locked
);
  localparam int ADDR_W = $clog2(WORDS);
  localparam int ABITS  = (WORDS == 64) ? `SEBP_ADDR_BITS_SMALL
                                        : `SEBP_ADDR_BITS_LARGE;
  localparam int SUB_HI = ABITS - 1;
  localparam int PAGE   = `SEBP_PAGE_WORDS;
  localparam logic [7:0] ADDR_MASK = 8'(WORDS - 1);
  localparam logic [7:0] LAST_WORD = 8'(WORDS - 1);
  localparam logic [`SEBP_TIMER_W-1:0] TIMER_LOAD =
    `SEBP_TIMER_W'(PROG_CYCLES - 1);

  // Only the three sizes of the family are served.
  generate
    if (!(WORDS == 64 || WORDS == 128 || WORDS == 256)) begin : g_bad_words
      $error("WORDS must be 64, 128 or 256");
    end
    if (PROG_CYCLES <= WORDS || PROG_CYCLES > (1 << `SEBP_TIMER_W))
    begin : g_bad_cycles
      $error("PROG_CYCLES out of range");
    end
  endgenerate

  logic [`SEBP_WORD_W-1:0] mem [WORDS];

  sebp_core_type c_reg;
  sebp_core_type c_next;

  logic [7:0]  link_ptr;
  logic [1:0]  link_op;
  logic        link_pre;
  logic [7:0]  link_addr;
  logic [15:0] link_word;
  logic        link_tgl;
  logic        link_q;
  logic        link_q_oe;
  logic [15:0] rd_word;
  logic [PAGE-1:0] page_hit;
  logic [PAGE-1:0] page_used;

  // The array only changes while busy, and reads are refused then unless the
  // start bit comes on one of the first two serial clock edges of a frame, before busy has passed the link's two-stage synchroniser.
  assign rd_word = mem[link_ptr[ADDR_W-1:0]];

  sebp_link #(
    .WORDS (WORDS),
    .ABITS (ABITS)
  ) u_link (
    .sclk      (sclk),
    .cs        (cs),
    .din       (din),
    .pre_pin   (pre_pin),
    .busy      (c_reg.busy),
    .rd_word   (rd_word),
    .rd_ptr    (link_ptr),
    .hdr_op    (link_op),
    .hdr_pre   (link_pre),
    .hdr_addr  (link_addr),
    .word_hold (link_word),
    .word_tgl  (link_tgl),
    .q         (link_q),
    .q_oe      (link_q_oe)
  );

  // Per page entry: is the word inside the area and is it present.
  genvar gi;
  generate
    for (gi = 0; gi < PAGE; gi++) begin : g_page
      logic [7:0] word_addr;
      assign word_addr = (c_reg.addr + 8'(gi)) & ADDR_MASK;
      assign page_hit[gi]  = !c_reg.prot_clr &&
                             (word_addr >= c_reg.prot_addr);
      assign page_used[gi] = (3'(gi) + 3'h1) < c_reg.fcnt;
    end
  endgenerate

  logic        cs_fall;
  logic        tg_evt;
  logic [2:0]  data_n;
  logic [1:0]  sub;
  logic        start_word;
  logic        start_fill;
  logic        start_timer;
  logic [2:0]  start_n;

  always_comb begin
    c_next       = c_reg;
    cs_fall      = c_reg.cs_d & ~c_reg.cs_s2;
    tg_evt       = (c_reg.tg_s2 ^ c_reg.tg_d) & c_reg.cs_s2;
    data_n       = (c_reg.fcnt == `SEBP_FCNT_MAX) ? 3'(PAGE)
                 : (c_reg.fcnt == 3'h0) ? 3'h0 : c_reg.fcnt - 3'h1;
    sub          = c_reg.addr[SUB_HI -: 2];
    start_word   = 1'b0;
    start_fill   = 1'b0;
    start_timer  = 1'b0;
    start_n      = 3'h0;

    c_next.cs_s1 = cs;
    c_next.cs_s2 = c_reg.cs_s1;
    c_next.cs_d  = c_reg.cs_s2;
    c_next.tg_s1 = link_tgl;
    c_next.tg_s2 = c_reg.tg_s1;
    c_next.tg_d  = c_reg.tg_s2;
    c_next.wr_go = 1'b0;

    // Frames that arrive while programming are not taken in.
    if (tg_evt && !c_reg.busy) begin
      if (c_reg.fcnt == 3'h0) begin
        c_next.op   = link_op;
        c_next.pre  = link_pre;
        c_next.addr = link_addr;
      end else if (c_reg.fcnt <= 3'(PAGE)) begin
        c_next.words[2'(c_reg.fcnt - 3'h1)] = link_word;
      end
      if (c_reg.fcnt != `SEBP_FCNT_MAX) begin
        c_next.fcnt = c_reg.fcnt + 3'h1;
      end
    end

    // Instructions act when the select falls, as the frame closes.
    if (cs_fall) begin
      c_next.fcnt = 3'h0;
      if (c_reg.state == SEBP_P_IDLE && !c_reg.busy &&
          c_reg.fcnt != 3'h0) begin
        if (!c_reg.pre) begin
          case (c_reg.op)
            `SEBP_OP_WRITE: begin
              if (c_reg.wen && data_n != 3'h0 && !page_hit[0]) begin
                start_word = 1'b1;
                start_n    = 3'h1;
              end
            end
            `SEBP_OP_PAGE: begin
              if (c_reg.wen && data_n != 3'h0 &&
                  (page_hit & page_used) == '0) begin
                start_word = 1'b1;
                start_n    = data_n;
              end
            end
            `SEBP_OP_EXT: begin
              case (sub)
                `SEBP_SUB_UNLOCK: begin
                  c_next.wen = 1'b1;
                end
                `SEBP_SUB_LOCK: begin
                  c_next.wen = 1'b0;
                end
                `SEBP_SUB_FILL: begin
                  if (c_reg.wen && data_n != 3'h0 && c_reg.prot_clr) begin
                    start_fill = 1'b1;
                  end
                end
                default: begin
                end
              endcase
            end
            default: begin
            end
          endcase
        end else if (c_reg.wen && !c_reg.otp) begin
          case (c_reg.op)
            `SEBP_OP_WRITE: begin
              c_next.prot_addr = c_reg.addr & ADDR_MASK;
              c_next.prot_clr  = 1'b0;
              start_timer      = 1'b1;
            end
            `SEBP_OP_PAGE: begin
              c_next.prot_addr = `SEBP_PROT_ADDR_RST;
              c_next.prot_clr  = 1'b1;
              start_timer      = 1'b1;
            end
            `SEBP_OP_EXT: begin
              if (sub == `SEBP_SUB_LOCK) begin
                c_next.otp  = 1'b1;
                start_timer = 1'b1;
              end
            end
            default: begin
            end
          endcase
        end
      end
    end

    if (start_word) begin
      c_next.wr_go = 1'b1;
      c_next.wr_n  = start_n;
    end

    // Counting on the system clock keeps the cycle going even when the
    // host stops the serial clock right after the frame.
    case (c_reg.state)
      SEBP_P_IDLE: begin
        if (start_word || start_timer) begin
          c_next.state = SEBP_P_WAIT;
          c_next.timer = TIMER_LOAD;
          c_next.busy  = 1'b1;
        end else if (start_fill) begin
          c_next.state    = SEBP_P_FILL;
          c_next.timer    = TIMER_LOAD;
          c_next.fill_ptr = 8'h00;
          c_next.busy     = 1'b1;
        end
      end
      SEBP_P_FILL: begin
        c_next.timer    = c_reg.timer - `SEBP_TIMER_W'(1);
        c_next.fill_ptr = c_reg.fill_ptr + 8'h01;
        if (c_reg.fill_ptr == LAST_WORD) begin
          c_next.state = SEBP_P_WAIT;
        end
      end
      SEBP_P_WAIT: begin
        c_next.timer = c_reg.timer - `SEBP_TIMER_W'(1);
        if (c_reg.timer == '0) begin
          c_next.state = SEBP_P_IDLE;
          c_next.busy  = 1'b0;
        end
      end
      default: begin
        c_next.state = SEBP_P_IDLE;
        c_next.busy  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      c_reg           <= '0;
      c_reg.state     <= SEBP_P_IDLE;
      c_reg.prot_addr <= `SEBP_PROT_ADDR_RST;
      c_reg.prot_clr  <= `SEBP_PROT_CLR_RST;
    end else begin
      c_reg <= c_next;
    end
  end

  // A cell is simply overwritten; the erase is implied by the write.
  always_ff @(posedge sys_clk) begin
    if (c_reg.wr_go) begin
      for (int i = 0; i < PAGE; i++) begin
        if (3'(i) < c_reg.wr_n) begin
          mem[ADDR_W'(c_reg.addr + 8'(i))] <= c_reg.words[i];
        end
      end
    end
    if (c_reg.state == SEBP_P_FILL) begin
      mem[c_reg.fill_ptr[ADDR_W-1:0]] <= c_reg.words[0];
    end
  end

  assign q              = link_q;
  assign q_oe           = link_q_oe;
  assign prog_busy      = c_reg.busy;
  assign write_unlocked = c_reg.wen;
  assign prot_locked    = c_reg.otp;

endmodule
`default_nettype wire

// file: verif/sebp_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
module sebp_chk
  import sebp_pkg::*;
#(
  parameter int PROG_CYCLES = 300
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic sclk,
  input wire logic cs,
  input wire logic din,
  input wire logic pre_pin,
  input wire logic q,
  input wire logic q_oe,
  input wire logic prog_busy,
  input wire logic write_unlocked,
  input wire logic prot_locked
);
  logic [23:0] cnt_reg;
  logic [23:0] cnt_next;
  // Counts how long the current programming cycle has been running.
  always_comb begin
    cnt_next = prog_busy ? cnt_reg + 24'h000001 : 24'h000000;
  end
  always_ff @(posedge sys_clk) begin
    cnt_reg <= reset_n ? cnt_next : 24'h000000;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  qoe_idle_a: assert property (!cs |-> !q_oe)
    else $error("q_oe high while deselected");
  reset_clear_a: assert property (disable iff (1'b0)
    !reset_n |=> !prog_busy && !write_unlocked && !prot_locked)
    else $error("state not cleared by reset");
  lock_sticky_a: assert property (prot_locked |=> prot_locked)
    else $error("lock bit cleared");
  busy_max_a: assert property (cnt_reg <= PROG_CYCLES + 3)
    else $error("programming cycle too long");
  busy_min_a: assert property (
    $fell(prog_busy) |-> cnt_reg >= PROG_CYCLES - 3)
    else $error("programming cycle cut short");
  busy_hold_a: assert property (
    $rose(prog_busy) |=> prog_busy[*8])
    else $error("busy dropped early");
  unlock_edge_a: assert property (
    $changed(write_unlocked) |-> !cs)
    else $error("unlock state changed while selected");
  lock_edge_a: assert property (
    $rose(prot_locked) |-> write_unlocked && !cs)
    else $error("lock bit set without unlock");
  busy_cov: cover property ($rose(prog_busy));
  lock_cov: cover property ($rose(prot_locked));
  relock_cov: cover property ($fell(write_unlocked));
endmodule
bind sebp_top sebp_chk #(.PROG_CYCLES(PROG_CYCLES)) u_chk (
  .sys_clk(sys_clk), .reset_n(reset_n), .sclk(sclk), .cs(cs),
  .din(din), .pre_pin(pre_pin), .q(q), .q_oe(q_oe),
  .prog_busy(prog_busy), .write_unlocked(write_unlocked),
  .prot_locked(prot_locked));
`default_nettype wire

// file: verif/sebp_host.sv
`timescale 1ns/1ps
`default_nettype none
module sebp_host (
  output logic      sclk,
  output logic      cs,
  output logic      din,
  output logic      pre_pin,
  input  wire logic q,
  input  wire logic q_oe
);
  logic [15:0] rdq [$];
  bit          saw_busy;
  bit          saw_ready;
  initial begin
    sclk = 1'b0;
    cs = 1'b1;
    din = 1'b0;
    pre_pin = 1'b0;
    // The link logic has no reset but a falling select, so give it one.
    #1 cs = 1'b0;
  end
  task automatic tick();
    #3 sclk = 1'b1;
    #3 sclk = 1'b0;
  endtask
  // The link clock only runs inside frames.
  task automatic frame(input logic p, input logic [79:0] b, input int n,
                       input int nrd);
    logic [15:0] w;
    rdq.delete();
    pre_pin = p;
    cs = 1'b1;
    #0.7;
    for (int i = n - 1; i >= 0; i--) begin
      din = b[i];
      tick();
    end
    for (int k = 0; k < nrd; k++) begin
      for (int j = 15; j >= 0; j--) begin
        din = ~din;
        tick();
        // An undriven line reads as the opposite bit, so a missing enable
        // shows up as a wrong word.
        w[j] = (q_oe === 1'b1) ? q : ~q;
      end
      rdq.push_back(w);
    end
    // Select stays up long enough for the core to see the last bit.
    #12 cs = 1'b0;
    din = ~din;
    pre_pin = ~p;
  endtask
  task automatic poll();
    saw_busy = 0;
    saw_ready = 0;
    din = 1'b0;
    cs = 1'b1;
    #0.7;
    for (int i = 0; i < 600 && !saw_ready; i++) begin
      tick();
      if (q_oe === 1'b1 && q === 1'b0) saw_busy = 1;
      if (q_oe === 1'b1 && q === 1'b1 && saw_busy) saw_ready = 1;
    end
    #12 cs = 1'b0;
    din = 1'b1;
  endtask
endmodule
`default_nettype wire

// file: verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import sebp_pkg::*;
  logic        sys_clk;
  logic        reset_n;
  logic        sclk, cs, din, pre_pin;
  wire logic   q, q_oe, prog_busy, write_unlocked, prot_locked;
  int          error_cnt;
  int          check_count;
  logic [31:0] seed = 32'h0000F3A3;
  logic [15:0] mem [256];
  logic [15:0] wv [4];
  logic [7:0]  a;
  bit          m_unl, m_otp, do_poll;
  bit          m_clr = 1;
  int          m_pa = 255;
  sebp_top #(.WORDS(256), .PROG_CYCLES(300)) DUT (
    .sys_clk(sys_clk), .reset_n(reset_n), .sclk(sclk), .cs(cs),
    .din(din), .pre_pin(pre_pin), .q(q), .q_oe(q_oe),
    .prog_busy(prog_busy), .write_unlocked(write_unlocked),
    .prot_locked(prot_locked));
  sebp_host host (.sclk(sclk), .cs(cs), .din(din), .pre_pin(pre_pin),
    .q(q), .q_oe(q_oe));
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk_bit(string nm, logic e, logic g);
    check_count++;
    if (e !== g) begin
      error_cnt++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic chk_word(string nm, logic [15:0] e, logic [15:0] g);
    check_count++;
    if (e !== g) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tend(string s);
    $display("test %s done", s);
  endtask
  function automatic bit prot(int x);
    return !m_clr && (x % 256) >= m_pa;
  endfunction
  // Returns the expected busy flag, or -1 for the extended instructions other than fill, where busy is not checked.
  function automatic int mdl(logic p, logic [1:0] op, logic [7:0] ad,
                             int nw);
    int n;
    if (!p && op == 2'h0 && ad[7:6] != 2'h1) begin
      m_unl = ad[7:6] == 2'h3;
      return -1;
    end
    if (!m_unl) return 0;
    if (p) begin
      if (m_otp) return 0;
      if (op == 2'h1) m_pa = ad;
      m_clr = op == 2'h3 || (op != 2'h1 && m_clr);
      if (op == 2'h3) m_pa = 255;
      if (op == 2'h0) m_otp = 1;
      return 1;
    end
    if (op == 2'h0) begin
      if (!m_clr) return 0;
      foreach (mem[i]) mem[i] = wv[0];
      return 1;
    end
    n = op == 2'h1 ? 1 : nw;
    for (int i = 0; i < n; i++) if (prot(int'(ad) + i)) return 0;
    for (int i = 0; i < n; i++) mem[(int'(ad) + i) % 256] = wv[i];
    return 1;
  endfunction
  task automatic cmd(input logic p, input logic [1:0] op,
                     input logic [7:0] ad, input int nw);
    logic [79:0] b;
    int          eb;
    b = {69'h0, 1'b1, op, ad};
    for (int i = 0; i < nw; i++) b = (b << 16) | {64'h0, wv[i]};
    eb = mdl(p, op, ad, nw);
    host.frame(p, b, 11 + 16 * nw, 0);
    repeat (12) @(posedge sys_clk);
    #1;
    chk_bit("q_oe", 1'b0, q_oe);
    if (eb >= 0) chk_bit("busy", eb[0], prog_busy);
    if (do_poll) begin
      host.poll();
      chk_bit("busy_q", 1'b1, host.saw_busy);
      chk_bit("ready_q", 1'b1, host.saw_ready);
    end
    for (int i = 0; i < 2000 && prog_busy !== 1'b0; i++) @(posedge sys_clk);
    #1;
    chk_bit("idle", 1'b0, prog_busy);
  endtask
  task automatic rd(input logic [7:0] ad, input int n);
    host.frame(1'b0, {69'h0, 1'b1, 2'h2, ad}, 11, n);
    for (int k = 0; k < n; k++)
      chk_word("read", mem[(int'(ad) + k) % 256], host.rdq[k]);
    repeat (4) @(posedge sys_clk);
  endtask
  initial begin
    #300000;
    error_cnt++;
    $display("ERROR watchdog expected end seen hang");
    summarize();
  end
  initial begin
    reset_n = 1'b0;
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (6) @(posedge sys_clk);
    #1;
    chk_bit("unlocked", 1'b0, write_unlocked);
    chk_bit("locked", 1'b0, prot_locked);
    wv[0] = rnd();
    cmd(1'b0, 2'h1, 8'h10, 1);
    cmd(1'b0, 2'h0, 8'hC0, 0);
    chk_bit("unlocked", 1'b1, write_unlocked);
    tend("power_up");
    wv[0] = rnd();
    cmd(1'b0, 2'h0, 8'h40, 1);
    rd(8'hFE, 3);
    for (int i = 0; i < 4; i++) begin
      a = 8'(rnd());
      wv[0] = rnd();
      cmd(1'b0, 2'h1, a, 1);
      rd(a, 1);
    end
    for (int i = 0; i < 4; i++) wv[i] = rnd();
    cmd(1'b0, 2'h3, 8'hFE, 4);
    rd(8'hFD, 6);
    // A short page stores only the words that were sent.
    for (int i = 0; i < 4; i++) wv[i] = rnd();
    cmd(1'b0, 2'h3, 8'h40, 2);
    rd(8'h3F, 4);
    do_poll = 1;
    cmd(1'b0, 2'h1, 8'h20, 1);
    do_poll = 0;
    rd(8'h20, 1);
    tend("write_read");
    cmd(1'b1, 2'h1, 8'h80, 0);
    for (int i = 0; i < 4; i++) wv[i] = rnd();
    cmd(1'b0, 2'h1, 8'h90, 1);
    cmd(1'b0, 2'h3, 8'h7E, 4);
    cmd(1'b0, 2'h1, 8'h7F, 1);
    cmd(1'b0, 2'h0, 8'h40, 1);
    rd(8'h7E, 4);
    rd(8'h90, 1);
    tend("protect");
    cmd(1'b1, 2'h3, 8'hFF, 0);
    cmd(1'b1, 2'h0, 8'h00, 0);
    chk_bit("locked", 1'b1, prot_locked);
    cmd(1'b1, 2'h1, 8'h00, 0);
    cmd(1'b0, 2'h1, 8'h90, 1);
    rd(8'h90, 1);
    cmd(1'b0, 2'h0, 8'h00, 0);
    chk_bit("unlocked", 1'b0, write_unlocked);
    wv[0] = rnd();
    cmd(1'b0, 2'h1, 8'h91, 1);
    rd(8'h90, 2);
    tend("lock");
    summarize();
  end
endmodule
`default_nettype wire
